// File: rtl/dvi_initiator.sv
// Policy-engine state machine issuing structured VDM requests as downstream port.
`timescale 1ns/1ps
module dvi_initiator
   import dvi_pkg::*;
#(
   parameter int unsigned RESP_CYC  = dvi_pkg::RESP_WAIT_CYC,
   parameter int unsigned ENTRY_CYC = dvi_pkg::ENTRY_WAIT_CYC,
   parameter int unsigned EXIT_CYC  = dvi_pkg::EXIT_WAIT_CYC
) (
   input  wire logic             sys_clk_i,
   input  wire logic             sys_rst_i,
   input  wire logic             is_supplier_i,
   input  wire logic             startup_i,
   input  wire dvi_pkg::dvi_op_t pm_op_i,
   input  wire logic             pm_identity_i,
   input  wire logic             pm_to_cable_i,
   input  wire logic             pm_ack_i,
   input  wire dvi_pkg::dvi_rx_t rx_i,
   input  wire logic             tx_ready_i,
   output dvi_pkg::dvi_tx_t      tx_o,
   output dvi_pkg::dvi_rpt_t     rpt_o,
   output logic                  idle_o,
   output logic                  supplier_full_reset_o,
   output logic                  consumer_full_reset_o,
   output logic                  busy_o
);
   import dvi_pkg::*;

   initial begin
      if (RESP_CYC < 2 || RESP_CYC >= (1 << TMR_W) || ENTRY_CYC < 2 || ENTRY_CYC >= (1 << TMR_W)
          || EXIT_CYC < 2 || EXIT_CYC >= (1 << TMR_W)) begin
         $error("timer counts out of range");
      end
   end

   typedef enum logic [4:0] {
      ST_IDLE, ST_STARTUP,
      ST_MODES_SEND, ST_MODES_REQ, ST_MODES_ACK, ST_MODES_FAIL,
      ST_ENTRY_SEND, ST_ENTRY_REQ, ST_ENTRY_ACK, ST_ENTRY_FAIL,
      ST_EXIT_SEND, ST_EXIT_REQ, ST_EXIT_ACK, ST_FULL_RESET,
      ST_ID_SEND, ST_ID_REQ, ST_ID_ACK, ST_ID_FAIL,
      ST_ATTN
   } dvi_state_t;

   dvi_state_t state_ff;
   dvi_state_t nxt_state;
   dvi_res_t   res_ff;
   logic       cable_ff;
   logic       tmr_start;
   logic       tmr_stop;
   logic [TMR_W-1:0] tmr_load;
   logic       tmr_expire;
   logic       rsp_ok;
   logic       in_req;
   dvi_cmd_t   req_cmd;

   always_comb begin
      unique case (state_ff)
         ST_MODES_SEND, ST_MODES_REQ: req_cmd = DVI_CMD_MODES;
         ST_ENTRY_SEND, ST_ENTRY_REQ: req_cmd = DVI_CMD_ENTER;
         ST_EXIT_SEND, ST_EXIT_REQ:   req_cmd = DVI_CMD_EXIT;
         default:                     req_cmd = DVI_CMD_IDENTITY;
      endcase
   end

   assign in_req = (state_ff == ST_MODES_REQ) || (state_ff == ST_ENTRY_REQ)
                || (state_ff == ST_EXIT_REQ) || (state_ff == ST_ID_REQ);
   assign rsp_ok = in_req && rx_i.valid && !rx_i.attention && (rx_i.cmd == req_cmd);

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_STARTUP: begin
            if (!startup_i) begin
               nxt_state = ST_IDLE;
            end else if (pm_identity_i) begin
               nxt_state = ST_ID_SEND;
            end
         end
         ST_IDLE: begin
            if (startup_i && is_supplier_i) begin
               nxt_state = ST_STARTUP;
            end else if (rx_i.valid && rx_i.attention) begin
               nxt_state = ST_ATTN;
            end else begin
               unique case (pm_op_i)
                  DVI_OP_MODES: nxt_state = ST_MODES_SEND;
                  DVI_OP_ENTER: nxt_state = ST_ENTRY_SEND;
                  DVI_OP_EXIT:  nxt_state = ST_EXIT_SEND;
                  DVI_OP_NONE:  nxt_state = ST_IDLE;
               endcase
            end
         end
         ST_MODES_SEND: if (tx_ready_i) nxt_state = ST_MODES_REQ;
         ST_ENTRY_SEND: if (tx_ready_i) nxt_state = ST_ENTRY_REQ;
         ST_EXIT_SEND:  if (tx_ready_i) nxt_state = ST_EXIT_REQ;
         ST_ID_SEND:    if (tx_ready_i) nxt_state = ST_ID_REQ;
         ST_MODES_REQ: begin
            if (rsp_ok) begin
               nxt_state = (rx_i.res == DVI_RES_ACK) ? ST_MODES_ACK : ST_MODES_FAIL;
            end else if (tmr_expire) begin
               nxt_state = ST_MODES_FAIL;
            end
         end
         ST_ENTRY_REQ: begin
            if (rsp_ok) begin
               nxt_state = (rx_i.res == DVI_RES_ACK) ? ST_ENTRY_ACK : ST_ENTRY_FAIL;
            end else if (tmr_expire) begin
               nxt_state = ST_ENTRY_FAIL;
            end
         end
         ST_EXIT_REQ: begin
            if (rsp_ok) begin
               nxt_state = (rx_i.res == DVI_RES_ACK) ? ST_EXIT_ACK : ST_FULL_RESET;
            end else if (tmr_expire) begin
               nxt_state = ST_FULL_RESET;
            end
         end
         ST_ID_REQ: begin
            if (rsp_ok) begin
               nxt_state = (rx_i.res == DVI_RES_ACK) ? ST_ID_ACK : ST_ID_FAIL;
            end else if (tmr_expire) begin
               nxt_state = ST_ID_FAIL;
            end
         end
         ST_MODES_ACK, ST_MODES_FAIL, ST_ENTRY_ACK, ST_ENTRY_FAIL, ST_EXIT_ACK,
         ST_ID_ACK, ST_ID_FAIL, ST_ATTN: begin
            if (pm_ack_i) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_FULL_RESET: nxt_state = ST_FULL_RESET;
         default:       nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Outcome latched on leaving a request state.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         res_ff <= DVI_RES_ACK;
      end else if (in_req && rsp_ok) begin
         res_ff <= rx_i.res;
      end else if (in_req && tmr_expire) begin
         res_ff <= DVI_RES_TIMEOUT;
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cable_ff <= 1'b0;
      end else if (state_ff == ST_IDLE || state_ff == ST_STARTUP) begin
         cable_ff <= pm_to_cable_i;
      end
   end

   // The timer starts when the request is handed over and stops on any exit.
   always_comb begin
      tmr_start = 1'b0;
      tmr_load  = TMR_W'(RESP_CYC);
      unique case (state_ff)
         ST_MODES_SEND, ST_ID_SEND: tmr_start = tx_ready_i;
         ST_ENTRY_SEND: begin
            tmr_start = tx_ready_i;
            tmr_load  = TMR_W'(ENTRY_CYC);
         end
         ST_EXIT_SEND: begin
            tmr_start = tx_ready_i;
            tmr_load  = TMR_W'(EXIT_CYC);
         end
         default: tmr_start = 1'b0;
      endcase
   end

   assign tmr_stop = in_req && rsp_ok;

   dvi_timer #(
      .W (TMR_W)
   ) u_timer (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .start_i   (tmr_start),
      .load_i    (tmr_load),
      .stop_i    (tmr_stop),
      .expire_o  (tmr_expire)
   );

   always_comb begin
      tx_o.valid    = (state_ff == ST_MODES_SEND) || (state_ff == ST_ENTRY_SEND)
                   || (state_ff == ST_EXIT_SEND) || (state_ff == ST_ID_SEND);
      tx_o.cmd      = req_cmd;
      tx_o.to_cable = cable_ff;
   end

   always_comb begin
      rpt_o.valid      = 1'b0;
      rpt_o.cmd        = req_cmd;
      rpt_o.res        = res_ff;
      rpt_o.attention  = 1'b0;
      rpt_o.full_reset = (state_ff == ST_FULL_RESET);
      unique case (state_ff)
         ST_MODES_ACK, ST_MODES_FAIL: begin
            rpt_o.valid = 1'b1;
            rpt_o.cmd   = DVI_CMD_MODES;
         end
         ST_ENTRY_ACK, ST_ENTRY_FAIL: begin
            rpt_o.valid = 1'b1;
            rpt_o.cmd   = DVI_CMD_ENTER;
         end
         ST_EXIT_ACK: begin
            rpt_o.valid = 1'b1;
            rpt_o.cmd   = DVI_CMD_EXIT;
         end
         ST_ID_ACK, ST_ID_FAIL: begin
            rpt_o.valid = 1'b1;
            rpt_o.cmd   = DVI_CMD_IDENTITY;
         end
         ST_ATTN: begin
            rpt_o.valid     = 1'b1;
            rpt_o.attention = 1'b1;
         end
         default: rpt_o.valid = 1'b0;
      endcase
   end

   assign idle_o                = (state_ff == ST_IDLE);
   assign supplier_full_reset_o = (state_ff == ST_FULL_RESET) && is_supplier_i;
   assign consumer_full_reset_o = (state_ff == ST_FULL_RESET) && !is_supplier_i;
   assign busy_o                = !idle_o && (state_ff != ST_STARTUP);

   a_modes_fail_path: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      state_ff == ST_MODES_REQ && rsp_ok && rx_i.res != DVI_RES_ACK |=> state_ff == ST_MODES_FAIL)
      else $error("modes refusal did not fail");
   a_modes_ack_rpt: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      state_ff == ST_MODES_REQ && rsp_ok && rx_i.res == DVI_RES_ACK
      |=> rpt_o.valid && rpt_o.cmd == DVI_CMD_MODES && rpt_o.res == DVI_RES_ACK)
      else $error("modes ack not reported");
   a_entry_ack_go: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      state_ff == ST_ENTRY_REQ && rsp_ok && rx_i.res == DVI_RES_ACK |=> state_ff == ST_ENTRY_ACK)
      else $error("entry ack missed");
   a_exit_fail_reset: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      state_ff == ST_EXIT_REQ && tmr_expire |=> supplier_full_reset_o == is_supplier_i
      && consumer_full_reset_o == !is_supplier_i)
      else $error("exit timeout did not reset");
   a_timeout_code: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (state_ff == ST_MODES_REQ || state_ff == ST_ID_REQ) && tmr_expire && !rsp_ok
      |=> rpt_o.valid && rpt_o.res == DVI_RES_TIMEOUT)
      else $error("timeout not reported");
   a_done_to_idle: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      rpt_o.valid && pm_ack_i && !rpt_o.full_reset |=> idle_o)
      else $error("no return to idle");
   a_attn_enter: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      idle_o && !startup_i && rx_i.valid && rx_i.attention |=> rpt_o.valid && rpt_o.attention)
      else $error("attention missed");
   a_modes_start: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      idle_o && !startup_i && !(rx_i.valid && rx_i.attention) && pm_op_i == DVI_OP_MODES
      |=> tx_o.valid && tx_o.cmd == DVI_CMD_MODES)
      else $error("modes request not sent");
   a_timer_quiet: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      !in_req |-> !tmr_expire)
      else $error("stale timer expiry");
   a_id_to_idle: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      state_ff == ST_ID_ACK && pm_ack_i |=> idle_o && !busy_o && !rpt_o.valid)
      else $error("identity ack did not return");

   c_modes_ok: cover property (@(posedge sys_clk_i) state_ff == ST_MODES_ACK);
   c_entry_fail: cover property (@(posedge sys_clk_i) state_ff == ST_ENTRY_FAIL);
   c_exit_reset: cover property (@(posedge sys_clk_i) state_ff == ST_FULL_RESET);
   c_attention: cover property (@(posedge sys_clk_i) state_ff == ST_ATTN);
endmodule

// File: rtl/dvi_pkg.sv
// Package with types and constants for the structured VDM initiator.
package dvi_pkg;
   localparam int unsigned CLK_HZ            = 10_000_000;
   localparam int unsigned RESP_WAIT_MS      = 30;
   localparam int unsigned ENTRY_WAIT_MS     = 50;
   localparam int unsigned EXIT_WAIT_MS      = 50;
   localparam int unsigned RESP_WAIT_CYC     = RESP_WAIT_MS * (CLK_HZ / 1000);
   localparam int unsigned ENTRY_WAIT_CYC    = ENTRY_WAIT_MS * (CLK_HZ / 1000);
   localparam int unsigned EXIT_WAIT_CYC     = EXIT_WAIT_MS * (CLK_HZ / 1000);
   localparam int unsigned TMR_W             = 20;

   typedef enum logic [1:0] {
      DVI_CMD_IDENTITY,
      DVI_CMD_MODES,
      DVI_CMD_ENTER,
      DVI_CMD_EXIT
   } dvi_cmd_t;

   typedef enum logic [1:0] {
      DVI_RES_ACK,
      DVI_RES_NAK,
      DVI_RES_BUSY,
      DVI_RES_TIMEOUT
   } dvi_res_t;

   typedef enum logic [1:0] {
      DVI_OP_NONE,
      DVI_OP_MODES,
      DVI_OP_ENTER,
      DVI_OP_EXIT
   } dvi_op_t;

   typedef struct packed {
      logic     valid;
      dvi_cmd_t cmd;
      logic     to_cable;
   } dvi_tx_t;

   typedef struct packed {
      logic     valid;
      dvi_cmd_t cmd;
      dvi_res_t res;
      logic     attention;
   } dvi_rx_t;

   typedef struct packed {
      logic     valid;
      dvi_cmd_t cmd;
      dvi_res_t res;
      logic     attention;
      logic     full_reset;
   } dvi_rpt_t;
endpackage

// File: rtl/dvi_timer.sv
// Down-counting wait timer with start, stop and one-cycle expiry pulse.
`timescale 1ns/1ps
module dvi_timer #(
   parameter int unsigned W = 20
) (
   input  wire logic         sys_clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic         start_i,
   input  wire logic [W-1:0] load_i,
   input  wire logic         stop_i,
   output logic              expire_o
);
   logic [W-1:0] cnt_ff;
   logic         run_ff;

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_ff <= '0;
         run_ff <= 1'b0;
      end else if (start_i) begin
         cnt_ff <= load_i;
         run_ff <= 1'b1;
      end else if (stop_i) begin
         run_ff <= 1'b0;
      end else if (run_ff) begin
         if (cnt_ff <= W'(1)) begin
            run_ff <= 1'b0;
         end
         cnt_ff <= cnt_ff - W'(1);
      end
   end

   assign expire_o = run_ff && !start_i && !stop_i && (cnt_ff <= W'(1));
endmodule

// File: test/dvi_partner.sv
// Behavioural protocol layer and port partner that answers the initiator's requests.
`timescale 1ns/1ps
module dvi_partner (
   input  wire logic             sys_clk_i,
   input  wire logic             sys_rst_i,
   input  wire dvi_pkg::dvi_tx_t tx_i,
   input  wire dvi_pkg::dvi_res_t res_i,
   input  wire logic [7:0]       dly_i,
   input  wire logic             att_i,
   output logic                  tx_ready_o,
   output dvi_pkg::dvi_rx_t      rx_o
);
   import dvi_pkg::*;
   logic [7:0] cnt_ff;
   logic       pend_ff;
   dvi_cmd_t   cmd_ff;
   // A timeout outcome is made by never answering; idle fields toggle so stale values never match.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tx_ready_o <= 1'b0;
         rx_o       <= '0;
         pend_ff    <= 1'b0;
         cnt_ff     <= 8'h00;
         cmd_ff     <= DVI_CMD_IDENTITY;
      end else begin
         tx_ready_o     <= tx_i.valid & ~tx_ready_o;
         rx_o.valid     <= 1'b0;
         rx_o.attention <= 1'b0;
         rx_o.cmd       <= dvi_cmd_t'(~rx_o.cmd);
         rx_o.res       <= dvi_res_t'(~rx_o.res);
         if (tx_i.valid && tx_ready_o) begin
            pend_ff <= (res_i != DVI_RES_TIMEOUT);
            cnt_ff  <= dly_i;
            cmd_ff  <= tx_i.cmd;
         end else if (pend_ff) begin
            if (cnt_ff == 8'h00) begin
               pend_ff    <= 1'b0;
               rx_o.valid <= 1'b1;
               rx_o.cmd   <= cmd_ff;
               rx_o.res   <= res_i;
            end else begin
               cnt_ff <= cnt_ff - 8'h01;
            end
         end else if (att_i) begin
            rx_o.valid     <= 1'b1;
            rx_o.attention <= 1'b1;
         end
      end
   end
endmodule

// File: test/tb_top.sv
// Self-checking bench for the structured message initiator.
`timescale 1ns/1ps
module tb_top;
   import dvi_pkg::*;
   localparam int unsigned TCYC = 20;
   logic     sys_clk_i, sys_rst_i, is_supplier_i, startup_i, pm_identity_i;
   logic     pm_to_cable_i, pm_ack_i, tx_ready_i, att, idle_o, sfr, cfr, busy_o;
   logic [7:0] dly_m;
   dvi_op_t  pm_op_i;
   dvi_rx_t  rx_i;
   dvi_tx_t  tx_o;
   dvi_rpt_t rpt_o;
   dvi_res_t res_m;
   int       n_errors, cmp_count;

   dvi_initiator #(.RESP_CYC(TCYC), .ENTRY_CYC(TCYC + 5), .EXIT_CYC(TCYC + 10)) u_dvi_initiator (
      .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .is_supplier_i(is_supplier_i),
      .startup_i(startup_i), .pm_op_i(pm_op_i), .pm_identity_i(pm_identity_i),
      .pm_to_cable_i(pm_to_cable_i), .pm_ack_i(pm_ack_i), .rx_i(rx_i), .tx_ready_i(tx_ready_i),
      .tx_o(tx_o), .rpt_o(rpt_o), .idle_o(idle_o), .supplier_full_reset_o(sfr),
      .consumer_full_reset_o(cfr), .busy_o(busy_o));
   dvi_partner u_dvi_partner (
      .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .tx_i(tx_o), .res_i(res_m),
      .dly_i(dly_m), .att_i(att), .tx_ready_o(tx_ready_i), .rx_o(rx_i));

   initial begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end

   task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic do_reset();
      @(posedge sys_clk_i);
      sys_rst_i <= 1'b1;
      repeat (20) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
   endtask

   // Issues one request (identity when op is none) and checks what goes out.
   task automatic req(dvi_op_t op, dvi_cmd_t cmd, dvi_res_t r);
      int n;
      @(posedge sys_clk_i);
      res_m <= r;
      dly_m <= 8'h03;
      if (op == DVI_OP_NONE) pm_identity_i <= 1'b1;
      else pm_op_i <= op;
      @(posedge sys_clk_i);
      pm_op_i       <= DVI_OP_NONE;
      pm_identity_i <= 1'b0;
      startup_i     <= 1'b0;
      for (n = 0; n < 50 && tx_o.valid !== 1'b1; n++) @(negedge sys_clk_i);
      chk("tx_valid", 8'(tx_o.valid), 8'h01);
      chk("tx_cmd", 8'(tx_o.cmd), 8'(cmd));
      chk("tx_cable", 8'(tx_o.to_cable), 8'(pm_to_cable_i));
   endtask

   // Waits for the report, checks it, acknowledges it and expects idle.
   task automatic rpt(dvi_cmd_t cmd, dvi_res_t r, logic at);
      int n;
      for (n = 0; n < 300 && rpt_o.valid !== 1'b1; n++) @(negedge sys_clk_i);
      chk("rpt_valid", 8'(rpt_o.valid), 8'h01);
      chk("rpt_att", 8'(rpt_o.attention), 8'(at));
      if (!at) chk("rpt_cmd", 8'(rpt_o.cmd), 8'(cmd));
      if (!at) chk("rpt_res", 8'(rpt_o.res), 8'(r));
      chk("rpt_busy", 8'(busy_o), 8'h01);
      chk("rpt_full_reset", 8'(rpt_o.full_reset), 8'h00);
      @(posedge sys_clk_i);
      pm_ack_i <= 1'b1;
      @(posedge sys_clk_i);
      pm_ack_i <= 1'b0;
      @(negedge sys_clk_i);
      chk("idle", 8'(idle_o), 8'h01);
      chk("idle_busy", 8'(busy_o), 8'h00);
      @(posedge sys_clk_i);
   endtask

   task automatic t_modes();
      for (int i = 0; i < 4; i++) begin
         req(DVI_OP_MODES, DVI_CMD_MODES, dvi_res_t'(i));
         rpt(DVI_CMD_MODES, dvi_res_t'(i), 1'b0);
      end
   endtask

   task automatic t_enter();
      pm_to_cable_i <= 1'b1;
      // The bench stands in for a manager already in the safe state.
      for (int i = 0; i < 4; i++) begin
         req(DVI_OP_ENTER, DVI_CMD_ENTER, dvi_res_t'(i));
         rpt(DVI_CMD_ENTER, dvi_res_t'(i), 1'b0);
      end
      // Normal operation is taken as restored once all four entries have finished.
      pm_to_cable_i <= 1'b0;
   endtask

   task automatic t_exit_ack();
      req(DVI_OP_EXIT, DVI_CMD_EXIT, DVI_RES_ACK);
      rpt(DVI_CMD_EXIT, DVI_RES_ACK, 1'b0);
   endtask

   task automatic t_ident();
      is_supplier_i <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         startup_i <= 1'b1;
         repeat (3) @(posedge sys_clk_i);
         req(DVI_OP_NONE, DVI_CMD_IDENTITY, dvi_res_t'(i));
         rpt(DVI_CMD_IDENTITY, dvi_res_t'(i), 1'b0);
      end
   endtask

   task automatic t_att();
      @(posedge sys_clk_i);
      att <= 1'b1;
      @(posedge sys_clk_i);
      att <= 1'b0;
      rpt(DVI_CMD_IDENTITY, DVI_RES_ACK, 1'b1);
   endtask

   task automatic t_stale();
      req(DVI_OP_MODES, DVI_CMD_MODES, DVI_RES_ACK);
      rpt(DVI_CMD_MODES, DVI_RES_ACK, 1'b0);
      repeat (TCYC + 10) @(negedge sys_clk_i);
      chk("stale_rpt", 8'(rpt_o.valid), 8'h00);
      chk("stale_idle", 8'(idle_o), 8'h01);
      @(posedge sys_clk_i);
   endtask

   task automatic t_exit_fail(logic sup, dvi_res_t r);
      int n;
      is_supplier_i <= sup;
      req(DVI_OP_EXIT, DVI_CMD_EXIT, r);
      for (n = 0; n < 300 && (sfr | cfr) !== 1'b1; n++) @(negedge sys_clk_i);
      chk("sup_reset", 8'(sfr), 8'(sup));
      chk("con_reset", 8'(cfr), 8'(!sup));
      chk("rpt_full_reset", 8'(rpt_o.full_reset), 8'h01);
      chk("reset_busy", 8'(busy_o), 8'h01);
      do_reset();
   endtask

   task automatic final_report();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk_i);
      n_errors++;
      final_report();
   end

   initial begin
      sys_rst_i     = 1'b1;
      is_supplier_i = 1'b0;
      startup_i     = 1'b0;
      pm_identity_i = 1'b0;
      pm_to_cable_i = 1'b0;
      pm_ack_i      = 1'b0;
      att           = 1'b0;
      dly_m         = 8'h03;
      pm_op_i       = DVI_OP_NONE;
      res_m         = DVI_RES_ACK;
      n_errors      = 0;
      cmp_count     = 0;
      do_reset();
      t_modes();
      t_enter();
      t_exit_ack();
      t_att();
      t_stale();
      t_ident();
      t_exit_fail(1'b0, DVI_RES_NAK);
      t_exit_fail(1'b1, DVI_RES_BUSY);
      t_exit_fail(1'b0, DVI_RES_TIMEOUT);
      final_report();
   end
endmodule
